// ### logic/asp_defines.svh
// Offsets, field positions, reset values and counts of the serial result port.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_OFF_STATUS   8'h00
`define ASP_OFF_MASK     8'h04
`define ASP_OFF_CLKDIV   8'h08
`define ASP_OFF_STATE    8'h0c
`define ASP_ST_RDERR     0
`define ASP_ST_DONE      1
`define ASP_EVT_BITS     2
`define ASP_MASK_RST     2'h0
`define ASP_CLKDIV_RST   8'h04
`define ASP_WORD_BITS    32
`define ASP_BITS_CNT     6'h20
`define ASP_LAST_BIT     6'h1f
`define ASP_FIRST_CH_CNT 6'h10
`define ASP_PH_CHANGE    2'h0
`define ASP_PH_RISE      2'h1
`define ASP_PH_FALL      2'h3
`define ASP_RESP_OKAY    2'h0
`define ASP_RESP_SLVERR  2'h2

`endif

// ### logic/asp_pkg.sv
// Types shared by the serial result port files.
// Assumes nothing of its surroundings.
package asp_pkg;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MSHIFT = 2'b01,
		ST_SSHIFT = 2'b10
	} asp_state_t;
endpackage

// ### logic/asp_shift_if.sv
// Carrier between the port control and the 32-bit result shifter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

interface asp_shift_if;
	logic                      load;
	logic [`ASP_WORD_BITS-1:0] load_word;
	logic                      shift;
	logic                      shift_in;
	logic                      msb;
	modport ctl (output load, output load_word, output shift, output shift_in, input msb);
	modport sr (input load, input load_word, input shift, input shift_in, output msb);
endinterface

`default_nettype wire

// ### logic/asp_shifter.sv
// 32-bit result shift register, most significant bit out first.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_shifter
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Control side
	asp_shift_if.sr   sh
);
	logic [`ASP_WORD_BITS-1:0] sreg_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sreg_r <= '0;
		end else if (sh.load) begin
			sreg_r <= sh.load_word;
		end else if (sh.shift) begin
			sreg_r <= {sreg_r[`ASP_WORD_BITS-2:0], sh.shift_in};
		end
	end

	assign sh.msb = sreg_r[`ASP_WORD_BITS-1];

	property p_load_msb;
		@(posedge aclk) disable iff (!aresetn)
		sh.load |=> sh.msb == $past(sh.load_word[`ASP_WORD_BITS-1]);
	endproperty
	a_load_msb: assert property (p_load_msb) else $error("msb not loaded first");
endmodule

`default_nettype wire

// ### logic/asp_serial_port.sv
// Serial result port of a dual simultaneous-sampling converter, AXI4-Lite registers.
// Assumes conversion events and results come from logic on aclk; pins are asynchronous.
//
// Notes on behaviour
// - Parallel mode drives bits 5-7 on shared pins; serial mode reads them as selects.
// - Parallel mode drives bits 8-10; serial mode drives data and frame, and shift clock in master clocking only.
// - Master frame marker active high with polarity select low, else active low.
// - Clock invert select flips shift clock sense in master and slave.
// - Slave clocking: chain input reappears on data output 32 periods later.
// - Master: read mode high shifts previous results during conversion, else after.
// - Both results sit in a 32-bit shift register, sent MSB first.
// - Channel order select sets which result leaves first.
// - Master clocking keeps data stable across both shift clock edges.
// - Slave, no invert: data changes on rising edge, host samples falling.
// - Slave, invert: data changes on falling edge, host samples rising.
// - Shift clock pin is output in master clocking, input in slave.
// - Frame marker only served when internal shift clock is selected.
// - Polarity low: marker high over read, brief low after first channel.
// - Polarity high: marker low over read, brief high after first channel.
// - Order select high sends channel A first, low sends channel B first.
// - Clock source low generates shift clock; high uses external clock.
// - Slave: conversion ending mid-read discards data and pulses read error.
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_serial_port
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Converter side
	input  wire logic        conv_start,
	input  wire logic        conv_done,
	input  wire logic [15:0] result_a,
	input  wire logic [15:0] result_b,
	input  wire logic [15:0] par_word,
	// Select pins
	input  wire logic        serial_mode_sel,
	input  wire logic        clock_source_sel,
	input  wire logic        channel_order_sel,
	input  wire logic        cs_n,
	// Shared pins 5 to 7
	input  wire logic [2:0]  mid_i,
	output var  logic [2:0]  mid_o,
	output var  logic [2:0]  mid_oe,
	// Shared pins 8 to 10
	output var  logic        serial_out,
	input  wire logic        sclk_i,
	output var  logic        sclk_o,
	output var  logic        sclk_oe,
	output var  logic        frame_marker,
	// Events
	output var  logic        read_error,
	output var  logic        irq
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] pin_raw;
	logic [7:0] s1_r;
	logic [7:0] s2_r;
	logic       ser_s;
	logic       ext_s;
	logic       ord_s;
	logic       csn_s;
	logic       sclk_s;
	logic       fpol_s;
	logic       cinv_s;
	logic       rdc_s;
	logic       sclk_d_r;

	assign pin_raw = {serial_mode_sel, clock_source_sel, channel_order_sel, cs_n,
		sclk_i, mid_i[0], mid_i[1], mid_i[2]};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	assign {ser_s, ext_s, ord_s, csn_s, sclk_s, fpol_s, cinv_s, rdc_s} = s2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end

	logic act_edge;
	logic master_en;
	logic slave_en;
	// Data moves on rising edge, or on falling edge when inverted
	assign act_edge  = cinv_s ? (~sclk_s & sclk_d_r) : (sclk_s & ~sclk_d_r);
	assign master_en = ser_s & ~ext_s;
	assign slave_en  = ser_s & ext_s;

	// ****************************************
	// Registers and state
	// ****************************************
	asp_state_t                state_r;
	logic [5:0]                bit_cnt_r;
	logic [1:0]                phase_r;
	logic                      sclk_lvl_r;
	logic [7:0]                div_cnt_r;
	logic [7:0]                clkdiv_r;
	logic [`ASP_EVT_BITS-1:0]  status_r;
	logic [`ASP_EVT_BITS-1:0]  mask_r;
	logic [15:0]               held_a_r;
	logic [15:0]               held_b_r;
	logic                      tick;
	logic                      err_evt;
	logic                      done_evt;
	logic                      fr_act;
	logic [`ASP_WORD_BITS-1:0] word_new;
	logic [`ASP_WORD_BITS-1:0] word_old;

	asp_shift_if sh ();

	asp_shifter u_shifter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sh      (sh.sr)
	);

	assign tick     = (state_r == ST_MSHIFT) && (div_cnt_r == 8'h00);
	assign word_new = ord_s ? {result_a, result_b} : {result_b, result_a};
	assign word_old = ord_s ? {held_a_r, held_b_r} : {held_b_r, held_a_r};
	assign err_evt  = slave_en && (state_r == ST_SSHIFT) && conv_done
		&& (bit_cnt_r < `ASP_BITS_CNT);
	assign done_evt = ((state_r == ST_MSHIFT) && tick && (phase_r == `ASP_PH_FALL)
		&& (bit_cnt_r == `ASP_LAST_BIT))
		|| ((state_r == ST_SSHIFT) && act_edge && !csn_s && (bit_cnt_r == `ASP_LAST_BIT));
	// Short inactive gap at the change of channel
	assign fr_act   = (state_r == ST_MSHIFT) && !((bit_cnt_r == `ASP_FIRST_CH_CNT)
		&& (phase_r == `ASP_PH_CHANGE));

	always_comb begin
		sh.load      = 1'b0;
		sh.load_word = word_new;
		sh.shift     = 1'b0;
		sh.shift_in  = slave_en & rdc_s;
		if (slave_en && conv_done) begin
			sh.load = 1'b1;
		end else if (master_en && (state_r == ST_IDLE)) begin
			if (rdc_s && conv_start) begin
				sh.load      = 1'b1;
				sh.load_word = word_old;
			end else if (!rdc_s && conv_done) begin
				sh.load = 1'b1;
			end
		end else if (state_r == ST_MSHIFT) begin
			sh.shift = tick && (phase_r == `ASP_PH_CHANGE) && (bit_cnt_r != 6'h00);
		end else if (state_r == ST_SSHIFT) begin
			sh.shift = act_edge && !csn_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_a_r <= 16'h0000;
			held_b_r <= 16'h0000;
		end else if (conv_done) begin
			held_a_r <= result_a;
			held_b_r <= result_b;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || state_r != ST_MSHIFT || div_cnt_r == 8'h00) begin
			div_cnt_r <= aresetn ? clkdiv_r : `ASP_CLKDIV_RST;
		end else begin
			div_cnt_r <= div_cnt_r - 8'h01;
		end
	end

	// ****************************************
	// Read sequencer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn || !ser_s) begin
			state_r    <= ST_IDLE;
			bit_cnt_r  <= 6'h00;
			phase_r    <= 2'h0;
			sclk_lvl_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					bit_cnt_r  <= 6'h00;
					phase_r    <= 2'h0;
					sclk_lvl_r <= 1'b0;
					if (master_en && sh.load) begin
						state_r <= ST_MSHIFT;
					end else if (slave_en && !conv_done && act_edge && !csn_s) begin
						state_r   <= ST_SSHIFT;
						bit_cnt_r <= 6'h01;
					end
				end
				ST_MSHIFT: begin
					if (!master_en) begin
						state_r <= ST_IDLE;
					end else if (tick) begin
						phase_r <= phase_r + 2'h1;
						if (phase_r == `ASP_PH_RISE) begin
							sclk_lvl_r <= 1'b1;
						end
						if (phase_r == `ASP_PH_FALL) begin
							sclk_lvl_r <= 1'b0;
							bit_cnt_r  <= bit_cnt_r + 6'h01;
							if (bit_cnt_r == `ASP_LAST_BIT) begin
								state_r <= ST_IDLE;
							end
						end
					end
				end
				ST_SSHIFT: begin
					if (!slave_en || conv_done) begin
						state_r <= ST_IDLE;
					end else if (act_edge && !csn_s && bit_cnt_r < `ASP_BITS_CNT) begin
						bit_cnt_r <= bit_cnt_r + 6'h01;
					end else if (csn_s && bit_cnt_r == `ASP_BITS_CNT) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pin outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mid_o        <= 3'h0;
			mid_oe       <= 3'h7;
			serial_out   <= 1'b0;
			sclk_o       <= 1'b0;
			sclk_oe      <= 1'b1;
			frame_marker <= 1'b0;
		end else begin
			mid_o      <= par_word[7:5];
			mid_oe     <= {3{~ser_s}};
			serial_out <= ser_s ? sh.msb : par_word[8];
			sclk_o     <= ser_s ? (sclk_lvl_r ^ cinv_s) : par_word[9];
			sclk_oe    <= ~ser_s | ~ext_s;
			if (!ser_s) begin
				frame_marker <= par_word[10];
			end else if (master_en) begin
				frame_marker <= fr_act ^ fpol_s;
			end else begin
				frame_marker <= fpol_s;
			end
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	logic                     wr_en;
	logic [`ASP_EVT_BITS-1:0] st_clr;
	logic                     aw_held_r;
	logic                     w_held_r;
	logic [7:0]               awaddr_r;
	logic [31:0]              wdata_r;
	logic                     wstrb0_r;

	assign wr_en  = aw_held_r && w_held_r && !s_axi_bvalid;
	assign st_clr = (wr_en && wstrb0_r && awaddr_r == `ASP_OFF_STATUS)
		? wdata_r[`ASP_EVT_BITS-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_error <= 1'b0;
			status_r   <= '0;
			irq        <= 1'b0;
		end else begin
			read_error <= err_evt;
			status_r   <= (status_r & ~st_clr) | {done_evt, err_evt};
			irq        <= |(status_r & mask_r);
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ASP_RESP_OKAY;
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb0_r      <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb0_r     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_r == `ASP_OFF_STATUS || awaddr_r == `ASP_OFF_MASK
					|| awaddr_r == `ASP_OFF_CLKDIV || awaddr_r == `ASP_OFF_STATE)
					? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held_r     <= 1'b0;
				w_held_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r   <= `ASP_MASK_RST;
			clkdiv_r <= `ASP_CLKDIV_RST;
		end else if (wr_en && wstrb0_r) begin
			if (awaddr_r == `ASP_OFF_MASK) begin
				mask_r <= wdata_r[`ASP_EVT_BITS-1:0];
			end else if (awaddr_r == `ASP_OFF_CLKDIV) begin
				clkdiv_r <= wdata_r[7:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ASP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `ASP_RESP_OKAY;
			if (s_axi_araddr == `ASP_OFF_STATUS) begin
				s_axi_rdata <= {30'h0, status_r};
			end else if (s_axi_araddr == `ASP_OFF_MASK) begin
				s_axi_rdata <= {30'h0, mask_r};
			end else if (s_axi_araddr == `ASP_OFF_CLKDIV) begin
				s_axi_rdata <= {24'h0, clkdiv_r};
			end else if (s_axi_araddr == `ASP_OFF_STATE) begin
				s_axi_rdata <= {18'h0, ser_s, ext_s, ord_s, fpol_s, cinv_s, rdc_s,
					bit_cnt_r, state_r};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `ASP_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_mid_dir;
		@(posedge aclk) disable iff (!aresetn)
		ser_s && $past(ser_s) |=> mid_oe == 3'h0;
	endproperty
	a_mid_dir: assert property (p_mid_dir) else $error("pins 5-7 driven in serial");

	property p_par_bit8;
		@(posedge aclk) disable iff (!aresetn)
		!ser_s |=> serial_out == $past(par_word[8]);
	endproperty
	a_par_bit8: assert property (p_par_bit8) else $error("bit 8 not on pin");

	property p_frame_active;
		@(posedge aclk) disable iff (!aresetn)
		master_en && state_r == ST_MSHIFT && bit_cnt_r == 6'h01 && $stable(fpol_s)
			|=> frame_marker == ~$past(fpol_s);
	endproperty
	a_frame_active: assert property (p_frame_active) else $error("frame not active");

	property p_frame_idle;
		@(posedge aclk) disable iff (!aresetn)
		master_en && state_r == ST_IDLE && $stable(fpol_s) |=> frame_marker == $past(fpol_s);
	endproperty
	a_frame_idle: assert property (p_frame_idle) else $error("frame not idle");

	property p_slave_clk_in;
		@(posedge aclk) disable iff (!aresetn)
		slave_en ##1 slave_en |=> !sclk_oe;
	endproperty
	a_slave_clk_in: assert property (p_slave_clk_in) else $error("clock driven in slave");

	property p_chain_in;
		@(posedge aclk) disable iff (!aresetn)
		slave_en && state_r == ST_SSHIFT && sh.shift |=> u_shifter.sreg_r[0] == $past(rdc_s);
	endproperty
	a_chain_in: assert property (p_chain_in) else $error("chain bit lost");

	property p_order_a;
		@(posedge aclk) disable iff (!aresetn)
		slave_en && conv_done && ord_s |-> sh.load && sh.load_word[31:16] == result_a;
	endproperty
	a_order_a: assert property (p_order_a) else $error("channel A not first");

	property p_rd_err;
		@(posedge aclk) disable iff (!aresetn)
		slave_en && state_r == ST_SSHIFT && conv_done && bit_cnt_r < `ASP_BITS_CNT
			|=> read_error ##1 !read_error;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("read error not pulsed");

	property p_master_stable;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ST_MSHIFT && sh.shift |-> phase_r == `ASP_PH_CHANGE && !sclk_lvl_r;
	endproperty
	a_master_stable: assert property (p_master_stable) else $error("data moved at edge");
endmodule

`default_nettype wire

// ### sim/asp_host_model.sv
// Host serial port model: samples master frames and clocks slave reads.
// Assumes the bench resolves the shift clock pin from the port's output enable.
`timescale 1ns/1ps
`default_nettype none

module asp_host_model (
	// Clock
	input  wire logic aclk,
	// Pins seen by the host
	input  wire logic sclk_pin,
	input  wire logic serial_out,
	input  wire logic frame_marker,
	input  wire logic cinv,
	input  wire logic fpol,
	// Host driven pins
	output var  logic host_sclk,
	output var  logic cs_n,
	output var  logic chain_in
);
	logic [31:0] cap;
	logic        prv;
	logic        fprv;
	logic        seen;
	logic        first_lvl;
	logic        mid_drop;
	int          cnt;
	int          drops;
	int          ferr;

	initial begin
		host_sclk = 1'b0;
		cs_n      = 1'b0;
		chain_in  = 1'b0;
	end

	task automatic clear();
		seen     = 1'b0;
		mid_drop = 1'b0;
		cnt      = 0;
		drops    = 0;
		ferr     = 0;
	endtask

	// ****************************************
	// Master frames
	// ****************************************
	always @(posedge aclk) begin
		prv  <= sclk_pin;
		fprv <= frame_marker;
		if (sclk_pin !== prv && !seen) begin
			seen      <= 1'b1;
			first_lvl <= sclk_pin;
		end
		if (sclk_pin !== prv && sclk_pin === !cinv) begin
			cap <= {cap[30:0], serial_out};
			cnt <= cnt + 1;
			if (frame_marker !== !fpol)
				ferr <= ferr + 1;
		end
		if (sclk_pin !== prv && sclk_pin === cinv && cnt > 0 && serial_out !== cap[0])
			ferr <= ferr + 1;
		if (frame_marker !== fprv && frame_marker === fpol) begin
			drops <= drops + 1;
			if (cnt == 16)
				mid_drop <= 1'b1;
		end
	end

	// ****************************************
	// Slave reads, clock stands still between them
	// ****************************************
	task automatic sread(input int n, input logic [31:0] ch, output logic [63:0] got);
		got       = '0;
		host_sclk = cinv;
		#41;
		cs_n = 1'b0;
		#20;
		for (int p = 1; p <= n; p++) begin
			host_sclk = !cinv;
			#32;
			host_sclk = cinv;
			got       = {got[62:0], serial_out};
			chain_in  = (p <= 32) ? ch[32 - p] : !chain_in;
			#32;
		end
		cs_n     = 1'b1;
		chain_in = !chain_in;
	endtask
endmodule

`default_nettype wire

// ### sim/adc_serial_result_port_tb_top.sv
// Self-checking bench of the serial result port with a host model.
// Assumes the design and the host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module adc_serial_result_port_tb_top;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, conv_start, conv_done, serial_mode_sel, clock_source_sel;
	logic        channel_order_sel, cs_n, serial_out, sclk_i, sclk_o, sclk_oe, frame_marker;
	logic        read_error, irq, host_sclk, chain_in, cinv, fpol, rd_mode;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, d, ch;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [15:0] result_a, result_b, par_word, ra, rb;
	logic [2:0]  mid_i, mid_o, mid_oe, mid_drv;
	logic [63:0] got;
	int          n_fail = 0;
	int          n_tests = 0;
	int          n_err = 0;

	assign sclk_i  = sclk_oe ? sclk_o : host_sclk;
	assign mid_drv = {clock_source_sel ? chain_in : rd_mode, cinv, fpol};
	assign mid_i   = (mid_oe & mid_o) | (~mid_oe & mid_drv);

	asp_serial_port asp_serial_port_inst (.*);
	asp_host_model asp_host_model_inst (.aclk, .sclk_pin(sclk_i), .serial_out, .frame_marker,
		.cinv, .fpol, .host_sclk, .cs_n, .chain_in);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	always @(posedge aclk) if (read_error === 1'b1) n_err <= n_err + 1;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] expw(input logic o, input logic [15:0] a, input logic [15:0] b);
		return o ? {a, b} : {b, a};
	endfunction

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v    = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	task automatic conv(input logic done, input logic [15:0] a, input logic [15:0] b);
		result_a   <= a;
		result_b   <= b;
		conv_done  <= done;
		conv_start <= !done;
		@(posedge aclk);
		conv_done  <= 1'b0;
		conv_start <= 1'b0;
	endtask

	initial begin
		repeat (30000) @(posedge aclk);
		n_fail++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'hc022ccc2;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, conv_start, conv_done, serial_mode_sel} = '0;
		{clock_source_sel, channel_order_sel, cinv, fpol, rd_mode, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, result_a, result_b, par_word} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axr(`ASP_OFF_CLKDIV, d, r);
		chk(d, `ASP_CLKDIV_RST);
		axr(`ASP_OFF_MASK, d, r);
		chk({irq, d}, {1'b0, 30'h0, `ASP_MASK_RST});
		axr(8'h10, d, r);
		chk({r, d}, {`ASP_RESP_SLVERR, 32'h0});
		axw(8'h10, 32'h1, r);
		chk(r, `ASP_RESP_SLVERR);
		axw(`ASP_OFF_CLKDIV, 32'h1, r);
		axr(`ASP_OFF_CLKDIV, d, r);
		chk({r, d}, {`ASP_RESP_OKAY, 32'h1});
		for (int i = 0; i < 4; i++) begin
			par_word <= 16'(xs());
			repeat (6) @(posedge aclk);
			chk({mid_oe, mid_o}, {3'b111, par_word[7:5]});
			chk({sclk_o, serial_out, sclk_oe, frame_marker}, {par_word[9:8], 1'b1, par_word[10]});
		end
		serial_mode_sel <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			{rd_mode, channel_order_sel, fpol, cinv} <= 4'(i);
			ra = 16'(xs());
			rb = 16'(xs());
			repeat (12) @(posedge aclk);
			asp_host_model_inst.clear();
			chk(mid_oe, 3'b000);
			conv(rd_mode, rd_mode ? ra : ~ra, rd_mode ? rb : ~rb);
			repeat (40) @(posedge aclk);
			chk({asp_host_model_inst.cnt, frame_marker}, {32'd0, fpol});
			conv(!rd_mode, rd_mode ? ~ra : ra, rd_mode ? ~rb : rb);
			for (int k = 0; k < 2000 && asp_host_model_inst.cnt < 32; k++) @(posedge aclk);
			repeat (20) @(posedge aclk);
			chk({asp_host_model_inst.cnt, asp_host_model_inst.cap},
				{32'd32, expw(channel_order_sel, ra, rb)});
			chk(asp_host_model_inst.ferr, 0);
			chk({asp_host_model_inst.mid_drop, asp_host_model_inst.drops}, {1'b1, 32'd2});
			chk(asp_host_model_inst.first_lvl, !cinv);
			chk({sclk_oe, frame_marker}, {1'b1, fpol});
		end
		clock_source_sel <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			{cinv, fpol, channel_order_sel} <= {1'(i), 2'(xs())};
			ra = 16'(xs());
			rb = 16'(xs());
			ch = xs();
			repeat (12) @(posedge aclk);
			conv(1'b1, ra, rb);
			if (i == 2) begin
				asp_host_model_inst.sread(10, ch, got);
				@(posedge aclk);
				ra = 16'(xs());
				conv(1'b1, ra, rb);
				repeat (8) @(posedge aclk);
				chk(n_err, 1);
			end
			asp_host_model_inst.sread(64, ch, got);
			chk(got, {expw(channel_order_sel, ra, rb), ch});
			chk({sclk_oe, frame_marker}, {1'b0, fpol});
		end
		@(posedge aclk);
		axr(`ASP_OFF_STATUS, d, r);
		chk({irq, d[`ASP_ST_DONE], d[`ASP_ST_RDERR]}, 3'b011);
		axw(`ASP_OFF_MASK, 32'h1, r);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		s_axi_wstrb <= 4'h0;
		axw(`ASP_OFF_MASK, 32'h0, r);
		s_axi_wstrb <= 4'hf;
		repeat (2) @(posedge aclk);
		chk({r, irq}, {`ASP_RESP_OKAY, 1'b1});
		axw(`ASP_OFF_STATUS, 32'h1, r);
		repeat (2) @(posedge aclk);
		axr(`ASP_OFF_STATUS, d, r);
		chk({irq, d[`ASP_ST_DONE], d[`ASP_ST_RDERR]}, 3'b010);
		axr(`ASP_OFF_STATE, d, r);
		chk(d, {18'h0, serial_mode_sel, clock_source_sel, channel_order_sel, fpol, cinv, chain_in, 8'h00});
		give_verdict();
	end
endmodule

`default_nettype wire
